/* File: core/rtca_alarm.sv */
/*
  Alarm compare block: alarm time register, repeat counter, running clock,
  sticky status with mask, AXI4-Lite register slave.
  Assumes one 125 MHz core clock. i_por_rst is the power-on reset and is
  the only reset of the alarm control register; the alarm time register has no reset; i_rst resets the rest.
*/
`timescale 1ns/1ps
`include "rtca_cfg.svh"

// How it works
// R1 - Eight-bit repeat count; alarm fires count plus one times.
// R2 - Control register holding repeat count cleared only by power-on reset.
// R3 - Alarm time bits 31-28 hold hour tens digit, 0 to 2.
// R4 - Alarm time bits 27-24 hold hour units digit, 0 to 9.
// R5 - Alarm time bits 23-20 hold minute tens digit, 0 to 5.
// R6 - Alarm time bits 19-16 hold minute units digit, 0 to 9.
// R7 - Alarm time bits 15-12 hold second tens digit, 0 to 5.
// R8 - Alarm time bits 11-8 hold second units digit, 0 to 9.
// R9 - Alarm time bits 7-0 read zero and ignore writes.
// R10 - Time match while enabled raises event, decrements count until exhausted.
// R11 - Alarm digits are read-write; undefined until software loads them.
module rtca_alarm #(
  parameter int unsigned SEC_CYCLES = `RTCA_SEC_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_por_rst,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_alarm_pulse,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [11:0] awaddr_reg;
  logic aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_have_reg;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [7:0] rpt_reg;
  logic en_reg;
  logic [31:0] time_reg;
  logic [7:0] left_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [1:0] stat_set;
  logic tick;
  logic match;
  logic fire;
  logic load_now;
  rtca_pkg::rtca_time_s now;
  rtca_pkg::rtca_time_s alarm_time;
  rtca_pkg::rtca_state_e state_reg;

  // ---------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ---------------------------------------------------------------
  assign o_awready = !aw_have_reg && !o_bvalid;
  assign o_wready = !w_have_reg && !o_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !o_bvalid;

  // Byte lanes expanded to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
    end
  endgenerate

  // Hold address until the pair completes
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end else if (i_awvalid && o_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= i_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  // Hold data until the pair completes
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg <= i_wdata;
      wstrb_reg <= i_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // Writable offsets; others answer SLVERR
  always_comb begin
    case (awaddr_reg)
      `RTCA_OFS_CTRL: wr_hit = 1'b1;
      `RTCA_OFS_TIME: wr_hit = 1'b1;
      `RTCA_OFS_STAT: wr_hit = 1'b1;
      `RTCA_OFS_MASK: wr_hit = 1'b1;
      `RTCA_OFS_NOW: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response, held until bready
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_hit ? 2'h0 : 2'h2;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control register: survives every reset except power-on
  // ---------------------------------------------------------------
  // R2 - power-on only
  always_ff @(posedge i_core_clk or posedge i_por_rst) begin
    if (i_por_rst) begin
      {en_reg, rpt_reg} <= 9'h000;
    end else if (wr_fire && awaddr_reg == `RTCA_OFS_CTRL) begin
      // R1 - eight-bit count
      if (wstrb_reg[0]) begin
        rpt_reg <= wdata_reg[`RTCA_CTRL_RPT_LSB +: 8];
      end
      if (wstrb_reg[1]) begin
        en_reg <= wdata_reg[`RTCA_CTRL_EN_BIT];
      end
    end
  end

  // R3 - field layout via struct
  // R4 - hour units field
  // R5 - minute tens field
  // R6 - minute units field
  // R7 - second tens field
  // R8 - second units field
  assign alarm_time = rtca_pkg::rtca_time_s'(time_reg[31:8]);

  // Alarm time has no reset: undefined until software writes it
  // R11 - read write digits
  // R9 - low byte dropped
  always_ff @(posedge i_core_clk) begin
    if (wr_fire && awaddr_reg == `RTCA_OFS_TIME) begin
      time_reg <= ((time_reg & ~wmask) | (wdata_reg & wmask)) &
                  `RTCA_TIME_IMPL_MASK;
    end
  end

  // Mask register, same layout as status
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_reg <= `RTCA_MASK_RESET;
    end else if (wr_fire && awaddr_reg == `RTCA_OFS_MASK && wstrb_reg[0]) begin
      mask_reg <= wdata_reg[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Timebase and running clock
  // ---------------------------------------------------------------
  assign load_now = wr_fire && awaddr_reg == `RTCA_OFS_NOW &&
                    (&wstrb_reg[3:1]);

  rtca_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  rtca_clock u_clock (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_load(load_now),
    .i_load_time(rtca_pkg::rtca_time_s'(wdata_reg[31:8])),
    .o_now(now)
  );

  // ---------------------------------------------------------------
  // Match and fire sequencer
  // ---------------------------------------------------------------
  // Compare only on a tick so one second of match fires once
  assign match = tick && (now == alarm_time);
  // Enable gates the fire too, so a disable in the match cycle drops it
  assign fire = (state_reg == rtca_pkg::RTCA_ARMED) && en_reg && match;

  // Arming reloads the remaining count from the repeat value
  // R10 - match and decrement
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= rtca_pkg::RTCA_IDLE;
      left_reg <= 8'h00;
    end else begin
      case (state_reg)
        rtca_pkg::RTCA_IDLE: begin
          if (en_reg) begin
            state_reg <= rtca_pkg::RTCA_ARMED;
            left_reg <= rpt_reg;
          end
        end
        rtca_pkg::RTCA_ARMED: begin
          if (!en_reg) begin
            state_reg <= rtca_pkg::RTCA_IDLE;
          end else if (fire) begin
            // R1 - count plus one firings
            if (left_reg == 8'h00) begin
              state_reg <= rtca_pkg::RTCA_HOLD;
            end else begin
              left_reg <= left_reg - 8'h01;
            end
          end
        end
        rtca_pkg::RTCA_HOLD: begin
          // Exhausted; software disables to rearm
          if (!en_reg) begin
            state_reg <= rtca_pkg::RTCA_IDLE;
          end
        end
        default: state_reg <= rtca_pkg::RTCA_IDLE;
      endcase
    end
  end

  // One-cycle event pulse
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_alarm_pulse <= 1'b0;
    end else begin
      o_alarm_pulse <= fire;
    end
  end

  // ---------------------------------------------------------------
  // Sticky status: write one clears, a set in the same cycle wins
  // ---------------------------------------------------------------
  assign stat_set = {fire && left_reg == 8'h00, fire};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= 2'h0;
    end else if (wr_fire && awaddr_reg == `RTCA_OFS_STAT && wstrb_reg[0]) begin
      stat_reg <= (stat_reg & ~wdata_reg[1:0]) | stat_set;
    end else begin
      stat_reg <= stat_reg | stat_set;
    end
  end

  assign o_irq = |(stat_reg & mask_reg);

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign o_arready = !o_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    case (i_araddr)
      `RTCA_OFS_CTRL: rd_word = {22'h00_0000,
                                 state_reg != rtca_pkg::RTCA_IDLE,
                                 en_reg, rpt_reg};
      `RTCA_OFS_TIME: rd_word = time_reg & `RTCA_TIME_IMPL_MASK;
      `RTCA_OFS_STAT: rd_word = {30'h0000_0000, stat_reg};
      `RTCA_OFS_MASK: rd_word = {30'h0000_0000, mask_reg};
      `RTCA_OFS_NOW: rd_word = {now, 8'h00};
      `RTCA_OFS_LEFT: rd_word = {24'h00_0000, left_reg};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data registered, held until rready
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic past_valid_reg;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      past_valid_reg <= 1'b0;
    end else begin
      past_valid_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst || i_por_rst);

  count_decrement_a: assert property ( // R10
    fire && left_reg != 8'h00 |=> left_reg == $past(left_reg) - 8'h01)
    else $error("repeat count did not step down on alarm");
  last_fire_hold_a: assert property ( // R1
    fire && left_reg == 8'h00 |=> state_reg == rtca_pkg::RTCA_HOLD &&
    stat_reg[1])
    else $error("last firing did not exhaust the alarm");
  arm_loads_count_a: assert property ( // R1
    state_reg == rtca_pkg::RTCA_IDLE && en_reg
    |=> left_reg == $past(rpt_reg))
    else $error("arming did not load the repeat count");
  no_fire_idle_a: assert property ( // R10
    state_reg != rtca_pkg::RTCA_ARMED |-> ##1 !o_alarm_pulse)
    else $error("alarm pulse while not armed");
  pulse_on_match_a: assert property ( // R10
    past_valid_reg && state_reg == rtca_pkg::RTCA_ARMED && en_reg &&
    match |=> o_alarm_pulse)
    else $error("match while armed gave no pulse");
  time_low_zero_a: assert property ( // R9
    o_rvalid && $past(i_arvalid && o_arready &&
    i_araddr == `RTCA_OFS_TIME) |-> o_rdata[7:0] == 8'h00)
    else $error("alarm time low byte not zero");
  time_write_a: assert property ( // R11
    wr_fire && awaddr_reg == `RTCA_OFS_TIME && wstrb_reg == 4'hF
    |=> time_reg[31:8] == $past(wdata_reg[31:8]))
    else $error("alarm time write lost");
  ctrl_keep_a: assert property ( // R2
    !(wr_fire && awaddr_reg == `RTCA_OFS_CTRL) |=> $stable(rpt_reg))
    else $error("repeat count changed without a write");
  status_sticky_a: assert property ( // R10
    stat_reg[0] && !(wr_fire && awaddr_reg == `RTCA_OFS_STAT)
    |=> stat_reg[0])
    else $error("alarm status dropped by itself");
  irq_level_a: assert property ( // R10
    fire && mask_reg[0] && !(wr_fire && awaddr_reg == `RTCA_OFS_MASK)
    |=> o_irq)
    else $error("unmasked alarm event gave no interrupt");

  alarm_seen_c: cover property (o_alarm_pulse);
  exhausted_c: cover property (state_reg == rtca_pkg::RTCA_HOLD);
  irq_seen_c: cover property (o_irq);
  write_read_c: cover property (o_bvalid ##[1:4] o_rvalid);

endmodule

/* File: core/rtca_clock.sv */
/*
  Running BCD time of day, advanced once per tick, loadable by software.
  Assumes load and tick come from the same core clock.
*/
`timescale 1ns/1ps
`include "rtca_cfg.svh"

module rtca_clock (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_load,
  input rtca_pkg::rtca_time_s i_load_time,
  output rtca_pkg::rtca_time_s o_now
);

  rtca_pkg::rtca_time_s now_next;

  // BCD carry chain; 23:59:59 wraps to 00:00:00
  always_comb begin
    now_next = o_now;
    if (o_now.second_units_digit != 4'h9) begin
      now_next.second_units_digit = o_now.second_units_digit + 4'h1;
    end else begin
      now_next.second_units_digit = 4'h0;
      if (o_now.second_tens_digit != 4'h5) begin
        now_next.second_tens_digit = o_now.second_tens_digit + 4'h1;
      end else begin
        now_next.second_tens_digit = 4'h0;
        if (o_now.minute_units_digit != 4'h9) begin
          now_next.minute_units_digit = o_now.minute_units_digit + 4'h1;
        end else begin
          now_next.minute_units_digit = 4'h0;
          if (o_now.minute_tens_digit != 4'h5) begin
            now_next.minute_tens_digit = o_now.minute_tens_digit + 4'h1;
          end else begin
            now_next.minute_tens_digit = 4'h0;
            if (o_now.hour_tens_digit == 4'h2 &&
                o_now.hour_units_digit == 4'h3) begin
              now_next.hour_tens_digit = 4'h0;
              now_next.hour_units_digit = 4'h0;
            end else if (o_now.hour_units_digit == 4'h9) begin
              now_next.hour_units_digit = 4'h0;
              now_next.hour_tens_digit = o_now.hour_tens_digit + 4'h1;
            end else begin
              now_next.hour_units_digit = o_now.hour_units_digit + 4'h1;
            end
          end
        end
      end
    end
  end

  // Load has priority over the tick so software sees its value stick
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_now <= '0;
    end else if (i_load) begin
      o_now <= i_load_time;
    end else if (i_tick) begin
      o_now <= now_next;
    end
  end

endmodule

/* File: core/rtca_tick.sv */
/*
  One-second tick divider.
  Assumes one core clock; the tick is a one-cycle enable.
*/
`timescale 1ns/1ps
`include "rtca_cfg.svh"

module rtca_tick #(
  parameter int unsigned SEC_CYCLES = `RTCA_SEC_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  output logic o_tick
);

  logic [26:0] cnt_reg;

  // Free-running divider, wraps at one second
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 27'h000_0000;
      o_tick <= 1'b0;
    end else if (cnt_reg == 27'(SEC_CYCLES - 1)) begin
      cnt_reg <= 27'h000_0000;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 27'h000_0001;
      o_tick <= 1'b0;
    end
  end

endmodule

/* File: include/rtca_cfg.svh */
/*
  Register offsets, field positions, reset values and timing counts for
  the alarm compare block.
  Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef RTCA_CFG_SVH
`define RTCA_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RTCA_OFS_CTRL 12'h000
`define RTCA_OFS_TIME 12'h004
`define RTCA_OFS_STAT 12'h008
`define RTCA_OFS_MASK 12'h00C
`define RTCA_OFS_NOW 12'h010
`define RTCA_OFS_LEFT 12'h014

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RTCA_CTRL_RPT_LSB 0
`define RTCA_CTRL_EN_BIT 8
`define RTCA_CTRL_SET_BIT 9
`define RTCA_TIME_HT_LSB 28
`define RTCA_TIME_HU_LSB 24
`define RTCA_TIME_MT_LSB 20
`define RTCA_TIME_MU_LSB 16
`define RTCA_TIME_ST_LSB 12
`define RTCA_TIME_SU_LSB 8
`define RTCA_TIME_IMPL_MASK 32'hFFFF_FF00
`define RTCA_STAT_ALARM_BIT 0
`define RTCA_STAT_DONE_BIT 1

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RTCA_CTRL_RESET 10'h000
`define RTCA_MASK_RESET 2'h0
`define RTCA_CLK_HZ 125000000
`define RTCA_SEC_HZ 1
`define RTCA_SEC_CYCLES (`RTCA_CLK_HZ / `RTCA_SEC_HZ)

`endif

/* File: include/rtca_pkg.sv */
/*
  Types for the alarm compare block.
  Assumes nothing beyond the constants header.
*/
package rtca_pkg;

  // Time of day as six BCD digits
  typedef struct packed {
    logic [3:0] hour_tens_digit;
    logic [3:0] hour_units_digit;
    logic [3:0] minute_tens_digit;
    logic [3:0] minute_units_digit;
    logic [3:0] second_tens_digit;
    logic [3:0] second_units_digit;
  } rtca_time_s;

  // Alarm sequencer states
  typedef enum logic [1:0] {
    RTCA_IDLE,
    RTCA_ARMED,
    RTCA_HOLD
  } rtca_state_e;

endpackage

/* File: testbench/rtca_alarm_bench.sv */
/*
  Self-checking bench for the alarm compare block: register access over
  AXI4-Lite, repeat counting, status, mask and interrupt, reset domains.
  Assumes rtca_cfg.svh, rtca_pkg and the core files are compiled first.
*/
`timescale 1ns/1ps
`include "rtca_cfg.svh"

module rtca_alarm_bench;
  // Short second keeps 256 firings well inside the run budget
  localparam int SEC = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pulse, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h5348_e610;
  int n_fail = 0;
  int cmp_count = 0;
  int pulses = 0;

  rtca_alarm #(.SEC_CYCLES(SEC)) u_rtca_alarm (
    .i_core_clk(clk), .i_rst(rst), .i_por_rst(por_rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .o_alarm_pulse(pulse),
    .o_irq(irq)
  );

  // 125 MHz core clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Firing counter seen by the alarm scenarios
  always @(posedge clk) begin
    if (pulse === 1'b1) pulses <= pulses + 1;
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Sampling at the falling edge sees what the next rising edge takes
  task automatic wchk(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = ((awvalid & awready) === 1'b1);
      tw = ((wvalid & wready) === 1'b1);
      tb = ((bvalid & bready) === 1'b1);
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
      if (n > 100) begin
        n_fail++;
        close_out();
      end
    end
    check(32'(r), 32'(er));
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = ((arvalid & arready) === 1'b1);
      tr = ((rvalid & rready) === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
      if (n > 100) begin
        n_fail++;
        close_out();
      end
    end
    check(d, ed);
    check(32'(r), 32'(er));
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk);
    check(32'(irq), 32'(e));
  endtask

  // Load the running time with the alarm time, count firings after it
  task automatic fire(input logic [31:0] t, input int e);
    int p0, n;
    p0 = pulses;
    n = 0;
    wchk(`RTCA_OFS_NOW, t, 2'h0);
    while (pulses == p0 && n < 4 * SEC) begin
      @(negedge clk);
      n++;
    end
    check(32'(pulses - p0), 32'(e));
  endtask

  // Model: left starts at the count, drops per firing, last leaves 0
  task automatic run_alarm(input int cnt);
    logic [31:0] t;
    int k;
    seed = lfsr(seed);
    t = {3'h0, seed[0], 4'(seed[7:4] % 10), 4'(seed[10:8] % 6),
         4'(seed[15:12] % 10), 4'(seed[18:16] % 6),
         4'(seed[23:20] % 10), 8'h00};
    wchk(`RTCA_OFS_CTRL, 32'h0000_0000, 2'h0);
    wchk(`RTCA_OFS_STAT, 32'h0000_0003, 2'h0);
    wchk(`RTCA_OFS_MASK, 32'h0000_0001, 2'h0);
    wchk(`RTCA_OFS_TIME, t, 2'h0);
    wchk(`RTCA_OFS_CTRL, 32'h0000_0100 | 32'(cnt), 2'h0);
    rchk(`RTCA_OFS_LEFT, 32'(cnt), 2'h0);
    // Armed flag, enable and count read back while armed
    rchk(`RTCA_OFS_CTRL, 32'h0000_0300 | 32'(cnt), 2'h0);
    for (k = 1; k <= cnt + 1; k++) begin
      fire(t, 1);
      rchk(`RTCA_OFS_LEFT, (k <= cnt) ? 32'(cnt - k) : 0, 2'h0);
      irq_is(1'b1);
      wchk(`RTCA_OFS_STAT, 32'h0000_0001, 2'h0);
      irq_is(1'b0);
    end
    rchk(`RTCA_OFS_STAT, 32'h0000_0002, 2'h0);
    fire(t, 0);
    wchk(`RTCA_OFS_MASK, 32'h0000_0002, 2'h0);
    irq_is(1'b1);
    wchk(`RTCA_OFS_STAT, 32'h0000_0002, 2'h0);
    irq_is(1'b0);
    $display("test alarm count %0d done", cnt);
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Watchdog sized well above the 256-firing run
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    int i;
    int lsb[6] = '{28, 24, 20, 16, 12, 8};
    int mx[6] = '{2, 9, 5, 9, 5, 9};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    rchk(`RTCA_OFS_CTRL, 32'h0000_0000, 2'h0);
    rchk(`RTCA_OFS_STAT, 32'h0000_0000, 2'h0);
    rchk(`RTCA_OFS_MASK, 32'h0000_0000, 2'h0);
    $display("test reset values done");
    // Random words: digits stored as written, low byte never kept
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wchk(`RTCA_OFS_TIME, seed, 2'h0);
      rchk(`RTCA_OFS_TIME, seed & `RTCA_TIME_IMPL_MASK, 2'h0);
    end
    // Each digit alone at its top value, low byte written with ones
    for (i = 0; i < 6; i++) begin
      wchk(`RTCA_OFS_TIME, (32'(mx[i]) << lsb[i]) | 32'hFF, 2'h0);
      rchk(`RTCA_OFS_TIME, 32'(mx[i]) << lsb[i], 2'h0);
    end
    rchk(12'h018, 32'h0000_0000, 2'h2);
    wchk(`RTCA_OFS_LEFT, 32'h0000_0001, 2'h2);
    $display("test time register done");
    run_alarm(0);
    run_alarm(3);
    run_alarm(255);
    // Plain reset keeps the control word, power-on reset clears it
    wchk(`RTCA_OFS_CTRL, 32'h0000_005A, 2'h0);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(`RTCA_OFS_CTRL, 32'h0000_005A, 2'h0);
    // Running time restarts at midnight; first tick is still 8 edges off
    rchk(`RTCA_OFS_NOW, 32'h0000_0000, 2'h0);
    rst <= 1'b1;
    por_rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    rchk(`RTCA_OFS_CTRL, 32'h0000_0000, 2'h0);
    $display("test reset domains done");
    close_out();
  end
endmodule
